// file: core/rtc_calendar_alarm_regs.v
// Calendar day/month/year and minute/hour alarm registers with alarm match
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_calendar_alarm_consts.vh"

// Summary of operation
// - BCD day-of-month: tens in bits 5-4, units in 3-0, bits 7-6 read 0.
// - Binary month: value in bits 3-0, bits 7-4 always read 0.
// - BCD month: tens in bit 4, units in bits 3-0, bits 7-5 read 0.
// - Binary year: 12-bit value in bits 11-0, bits 15-12 read 0.
// - BCD year: century digits in bits 14-12 and 11-8, bit 15 reads 0.
// - BCD year: decade in bits 7-4 and lowest digit in bits 3-0.
// - Binary minute alarm: enable bit 7, minute 5-0, bit 6 reads 0.
// - Each alarm has its own enable; 0 disables, 1 enables its compare.
// - BCD minute alarm: enable bit 7, tens 6-4, units 3-0, none reserved.
// - Binary hour alarm: enable bit 7, hour 4-0, bits 6-5 read 0.
// - BCD hour alarm: enable bit 7, tens 5-4, units 3-0, bit 6 reads 0.
module rtc_calendar_alarm_regs #(
   parameter ADDR_WIDTH = 4,
   parameter DATA_WIDTH = 16
) (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Register port
   input wire [ADDR_WIDTH-1:0] reg_addr,
   input wire [DATA_WIDTH-1:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [DATA_WIDTH-1:0] reg_rdata,
   // Current time from the counting engine, same clock
   input wire [7:0] current_minute,
   input wire [7:0] current_hour,
   // Calendar values and format towards the counting engine
   output reg [7:0] calendar_day_of_month_reg,
   output reg [7:0] calendar_month_reg,
   output reg [15:0] calendar_year_reg,
   output reg bcd_mode,
   // Alarm
   output reg alarm_event,
   output reg alarm_flag
);

   ////////////////////////////////////////////////////////////////////////
   // Storage and decode

   reg [7:0] alarm_minute_reg;
   reg [7:0] alarm_hour_reg;
   reg match_prev;

   wire [3:0] addr_low;
   wire wr_fmt;
   wire wr_stat;
   wire wr_day;
   wire wr_mon;
   wire wr_year;
   wire wr_amin;
   wire wr_ahour;

   // Only the low four index bits decode, so upper bits alias
   assign addr_low = reg_addr[3:0];
   assign wr_fmt = reg_write && (addr_low == `ADDR_FORMAT_CTRL);
   assign wr_stat = reg_write && (addr_low == `ADDR_ALARM_STATUS);
   assign wr_day = reg_write && (addr_low == `ADDR_DAY_OF_MONTH);
   assign wr_mon = reg_write && (addr_low == `ADDR_MONTH);
   assign wr_year = reg_write && (addr_low == `ADDR_YEAR);
   assign wr_amin = reg_write && (addr_low == `ADDR_ALARM_MINUTE);
   assign wr_ahour = reg_write && (addr_low == `ADDR_ALARM_HOUR);

   ////////////////////////////////////////////////////////////////////////
   // Layout masks chosen by the format bit

   reg [7:0] day_mask;
   reg [7:0] mon_mask;
   reg [15:0] year_mask;
   reg [7:0] amin_mask;
   reg [7:0] ahour_mask;
   reg [7:0] amin_cmp;
   reg [7:0] ahour_cmp;

   // Storage is shared; the visible layout and the alarm compare widths change with the mode
   always @* begin
      if (bcd_mode) begin
         day_mask = `DAY_MASK_BCD;
      end else begin
         day_mask = `DAY_MASK_BIN;
      end
   end

   always @* begin
      if (bcd_mode) begin
         mon_mask = `MONTH_MASK_BCD;
      end else begin
         mon_mask = `MONTH_MASK_BIN;
      end
   end

   // Year layout
   always @* begin
      if (bcd_mode) begin
         year_mask = `YEAR_MASK_BCD;
      end else begin
         year_mask = `YEAR_MASK_BIN;
      end
   end

   // Alarm layouts
   always @* begin
      if (bcd_mode) begin
         amin_mask = `AMIN_MASK_BCD;
      end else begin
         amin_mask = `AMIN_MASK_BIN;
      end
   end

   always @* begin
      if (bcd_mode) begin
         ahour_mask = `AHOUR_MASK_BCD;
      end else begin
         ahour_mask = `AHOUR_MASK_BIN;
      end
   end

   // Compare widths leave the enable flag out
   always @* begin
      if (bcd_mode) begin
         amin_cmp = `AMIN_CMP_BCD;
      end else begin
         amin_cmp = `AMIN_CMP_BIN;
      end
   end

   always @* begin
      if (bcd_mode) begin
         ahour_cmp = `AHOUR_CMP_BCD;
      end else begin
         ahour_cmp = `AHOUR_CMP_BIN;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes

   // Bits that read zero in the current layout are also not stored by a write
   // Format select
   always @(posedge clk) begin
      if (!nrst) begin
         bcd_mode <= 1'b0;
      end else if (wr_fmt) begin
         bcd_mode <= reg_wdata[`FMT_BCD_BIT];
      end
   end

   // Day of month
   always @(posedge clk) begin
      if (!nrst) begin
         calendar_day_of_month_reg <= `RESET_BYTE;
      end else if (wr_day) begin
         calendar_day_of_month_reg <= reg_wdata[7:0] & day_mask;
      end
   end

   // Month
   always @(posedge clk) begin
      if (!nrst) begin
         calendar_month_reg <= `RESET_BYTE;
      end else if (wr_mon) begin
         calendar_month_reg <= reg_wdata[7:0] & mon_mask;
      end
   end

   // Year
   always @(posedge clk) begin
      if (!nrst) begin
         calendar_year_reg <= `RESET_WORD;
      end else if (wr_year) begin
         calendar_year_reg <= reg_wdata[15:0] & year_mask;
      end
   end

   // Minute alarm
   always @(posedge clk) begin
      if (!nrst) begin
         alarm_minute_reg <= `RESET_BYTE;
      end else if (wr_amin) begin
         alarm_minute_reg <= reg_wdata[7:0] & amin_mask;
      end
   end

   // Hour alarm
   always @(posedge clk) begin
      if (!nrst) begin
         alarm_hour_reg <= `RESET_BYTE;
      end else if (wr_ahour) begin
         alarm_hour_reg <= reg_wdata[7:0] & ahour_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Alarm match

   wire amin_enable;
   wire ahour_enable;
   wire min_equal;
   wire hour_equal;
   wire match_now;
   wire any_enable;
   wire min_ok;
   wire hour_ok;

   // Current values arrive on this clock, so they need no synchroniser
   assign amin_enable = alarm_minute_reg[`ALARM_ENABLE_BIT];
   assign ahour_enable = alarm_hour_reg[`ALARM_ENABLE_BIT];
   assign min_equal = ((alarm_minute_reg & amin_cmp) ==
                       (current_minute & amin_cmp));
   assign hour_equal = ((alarm_hour_reg & ahour_cmp) ==
                        (current_hour & ahour_cmp));
   // With no enable set there is no alarm at all
   assign any_enable = amin_enable || ahour_enable;
   assign min_ok = !amin_enable || min_equal;
   assign hour_ok = !ahour_enable || hour_equal;
   assign match_now = any_enable && min_ok && hour_ok;

   // Event on the entry into a match, so a match lasting a minute fires once
   always @(posedge clk) begin
      if (!nrst) begin
         match_prev <= 1'b0;
      end else begin
         match_prev <= match_now;
      end
   end

   always @(posedge clk) begin
      if (!nrst) begin
         alarm_event <= 1'b0;
      end else begin
         alarm_event <= match_now && !match_prev;
      end
   end

   // A new match beats a clear written in the same cycle
   always @(posedge clk) begin
      if (!nrst) begin
         alarm_flag <= 1'b0;
      end else if (match_now && !match_prev) begin
         alarm_flag <= 1'b1;
      end else if (wr_stat && reg_wdata[`STAT_FLAG_BIT]) begin
         alarm_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register reads, data one cycle after the strobe

   reg [DATA_WIDTH-1:0] read_mux;

   always @* begin
      read_mux = {DATA_WIDTH{1'b0}};
      // Unmapped indices fall through to zero
      case (addr_low)
         `ADDR_FORMAT_CTRL: begin
            read_mux[`FMT_BCD_BIT] = bcd_mode;
         end
         `ADDR_ALARM_STATUS: begin
            read_mux[`STAT_FLAG_BIT] = alarm_flag;
            read_mux[`STAT_MATCH_BIT] = match_now;
         end
         `ADDR_DAY_OF_MONTH: begin
            read_mux[7:0] = calendar_day_of_month_reg & day_mask;
         end
         `ADDR_MONTH: begin
            read_mux[7:0] = calendar_month_reg & mon_mask;
         end
         `ADDR_YEAR: begin
            read_mux[15:0] = calendar_year_reg & year_mask;
         end
         `ADDR_ALARM_MINUTE: begin
            read_mux[7:0] = alarm_minute_reg & amin_mask;
         end
         `ADDR_ALARM_HOUR: begin
            read_mux[7:0] = alarm_hour_reg & ahour_mask;
         end
         default: begin
            read_mux = {DATA_WIDTH{1'b0}};
         end
      endcase
   end

   // Read data only stand in the cycle after the strobe, zero otherwise
   always @(posedge clk) begin
      if (!nrst) begin
         reg_rdata <= {DATA_WIDTH{1'b0}};
      end else if (reg_read) begin
         reg_rdata <= read_mux;
      end else begin
         reg_rdata <= {DATA_WIDTH{1'b0}};
      end
   end

endmodule // rtc_calendar_alarm_regs
`default_nettype wire

// file: core/rtc_calendar_alarm_consts.vh
// Offsets, field layouts, masks and reset values of the calendar/alarm block
`ifndef RTC_CALENDAR_ALARM_CONSTS_VH
`define RTC_CALENDAR_ALARM_CONSTS_VH

// Register indices on the plain register port
`define ADDR_FORMAT_CTRL 4'h0
`define ADDR_ALARM_STATUS 4'h1
`define ADDR_DAY_OF_MONTH 4'h2
`define ADDR_MONTH 4'h3
`define ADDR_YEAR 4'h4
`define ADDR_ALARM_MINUTE 4'h5
`define ADDR_ALARM_HOUR 4'h6

// Format control and status bits
`define FMT_BCD_BIT 0
`define STAT_FLAG_BIT 0
`define STAT_MATCH_BIT 1

// Alarm enable flag position in both alarm registers
`define ALARM_ENABLE_BIT 7

// Writable/readable bits per register, binary form
`define DAY_MASK_BIN 8'h1f
`define MONTH_MASK_BIN 8'h0f
`define YEAR_MASK_BIN 16'h0fff
`define AMIN_MASK_BIN 8'hbf
`define AHOUR_MASK_BIN 8'h9f

// Writable/readable bits per register, BCD form
`define DAY_MASK_BCD 8'h3f
`define MONTH_MASK_BCD 8'h1f
`define YEAR_MASK_BCD 16'h7fff
`define AMIN_MASK_BCD 8'hff
`define AHOUR_MASK_BCD 8'hbf

// Compared value bits of the alarms (enable flag excluded)
`define AMIN_CMP_BIN 8'h3f
`define AMIN_CMP_BCD 8'h7f
`define AHOUR_CMP_BIN 8'h1f
`define AHOUR_CMP_BCD 8'h3f

// Reset values of storage
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000

`endif

// file: tb/rtc_calendar_alarm_regs_sva.sv
// Port assertions of the calendar and alarm register block
`timescale 1ns/100ps
`default_nettype none
module rtc_calendar_alarm_sva (
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Register port
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [15:0] reg_rdata,
   // Engine side
   input wire [7:0] current_minute,
   input wire [7:0] current_hour,
   input wire [7:0] calendar_day_of_month_reg,
   input wire [7:0] calendar_month_reg,
   input wire [15:0] calendar_year_reg,
   input wire bcd_mode,
   input wire alarm_event,
   input wire alarm_flag
);
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
// Mode is sampled at the read edge, the layout in force for that read
wire rd_bin = reg_read && !bcd_mode;
wire rd_bcd = reg_read && bcd_mode;
day_bcd_a: assert property (
   reg_read && reg_addr == 4'h2 |=> reg_rdata[15:6] == 0)
   else $error("day upper bits set");
mon_bin_a: assert property (
   rd_bin && reg_addr == 4'h3 |=> reg_rdata[15:4] == 0)
   else $error("month bits set");
mon_bcd_a: assert property (
   rd_bcd && reg_addr == 4'h3 |=> reg_rdata[15:5] == 0)
   else $error("month bits set");
year_bin_a: assert property (
   rd_bin && reg_addr == 4'h4 |=> reg_rdata[15:12] == 0)
   else $error("year bits set");
year_bcd_a: assert property (
   rd_bcd && reg_addr == 4'h4 |=> !reg_rdata[15])
   else $error("year bit set");
amin_bin_a: assert property (
   rd_bin && reg_addr == 4'h5 |=> reg_rdata[15:8] == 0 && !reg_rdata[6])
   else $error("minute bits set");
amin_bcd_a: assert property (
   rd_bcd && reg_addr == 4'h5 |=> reg_rdata[15:8] == 0)
   else $error("minute bits set");
ahour_bin_a: assert property (
   rd_bin && reg_addr == 4'h6 |=> reg_rdata[15:8] == 0 &&
   reg_rdata[6:5] == 0)
   else $error("hour bits set");
ahour_bcd_a: assert property (
   rd_bcd && reg_addr == 4'h6 |=> reg_rdata[15:8] == 0 && !reg_rdata[6])
   else $error("hour bits set");
event_once_a: assert property (
   alarm_event |-> alarm_flag ##1 !alarm_event)
   else $error("event not a pulse");
cover property (alarm_event);
cover property (rd_bcd && reg_addr == 4'h5);
cover property (reg_write && reg_addr == 4'h1 && reg_wdata[0] && alarm_flag);
endmodule // rtc_calendar_alarm_sva
bind rtc_calendar_alarm_regs rtc_calendar_alarm_sva chk_i (
   .clk(clk),
   .nrst(nrst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_write(reg_write),
   .reg_read(reg_read),
   .reg_rdata(reg_rdata),
   .current_minute(current_minute),
   .current_hour(current_hour),
   .calendar_day_of_month_reg(calendar_day_of_month_reg),
   .calendar_month_reg(calendar_month_reg),
   .calendar_year_reg(calendar_year_reg),
   .bcd_mode(bcd_mode),
   .alarm_event(alarm_event),
   .alarm_flag(alarm_flag)
);
`default_nettype wire

// file: tb/rtc_calendar_alarm_regs_tb_top.sv
// Random register and alarm traffic checked against a bench model
`timescale 1ns/100ps
`default_nettype none
`include "rtc_calendar_alarm_consts.vh"
module rtc_calendar_alarm_regs_tb_top;
logic clk = 0;
logic nrst = 0;
logic reg_write = 0;
logic reg_read = 0;
logic [3:0] reg_addr = 0;
logic [15:0] reg_wdata = 0;
logic [7:0] current_minute = 0;
logic [7:0] current_hour = 0;
logic [15:0] r = 16'h0017;
wire [15:0] reg_rdata;
wire [15:0] calendar_year_reg;
wire [7:0] calendar_day_of_month_reg;
wire [7:0] calendar_month_reg;
wire bcd_mode;
wire alarm_event;
wire alarm_flag;
logic [15:0] m [0:7];
logic [15:0] rd;
logic fmt, pm, ev, flag;
int n_errors = 0;
int num_checks = 0;
int k;
rtc_calendar_alarm_regs DUT (
   .clk(clk),
   .nrst(nrst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_write(reg_write),
   .reg_read(reg_read),
   .reg_rdata(reg_rdata),
   .current_minute(current_minute),
   .current_hour(current_hour),
   .calendar_day_of_month_reg(calendar_day_of_month_reg),
   .calendar_month_reg(calendar_month_reg),
   .calendar_year_reg(calendar_year_reg),
   .bcd_mode(bcd_mode),
   .alarm_event(alarm_event),
   .alarm_flag(alarm_flag)
);
initial forever #2.5 clk = ~clk;
function [15:0] lfsr(input [15:0] s);
   lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
endfunction
function [15:0] msk(input [3:0] a, input b);
   case (a)
      2: msk = b ? `DAY_MASK_BCD : `DAY_MASK_BIN;
      3: msk = b ? `MONTH_MASK_BCD : `MONTH_MASK_BIN;
      4: msk = b ? `YEAR_MASK_BCD : `YEAR_MASK_BIN;
      5: msk = b ? `AMIN_MASK_BCD : `AMIN_MASK_BIN;
      6: msk = b ? `AHOUR_MASK_BCD : `AHOUR_MASK_BIN;
      default: msk = 0;
   endcase
endfunction
//////////////////////////////////////////////////
// Model: a disabled alarm register drops out of the match
wire [7:0] cm = fmt ? `AMIN_CMP_BCD : `AMIN_CMP_BIN;
wire [7:0] ch = fmt ? `AHOUR_CMP_BCD : `AHOUR_CMP_BIN;
wire em = m[5][7];
wire eh = m[6][7];
wire hit_min = !em || ((current_minute ^ m[5][7:0]) & cm) == 0;
wire hit_hour = !eh || ((current_hour ^ m[6][7:0]) & ch) == 0;
wire hit = (em | eh) && hit_min && hit_hour;
always @(posedge clk) begin
   if (!nrst) begin
      {fmt, pm, ev, flag, rd} <= 0;
      for (int i = 0; i < 8; i++) m[i] <= 0;
   end else begin
      ev <= hit && !pm;
      pm <= hit;
      if (!reg_read) rd <= 0;
      else if (reg_addr == 0) rd <= {15'h0, fmt};
      else if (reg_addr == 1) rd <= {14'h0, hit, flag};
      else rd <= m[reg_addr[2:0]] & msk(reg_addr, fmt);
      if (reg_write && reg_addr > 1 && reg_addr < 7)
         m[reg_addr[2:0]] <= reg_wdata & msk(reg_addr, fmt);
      if (reg_write && reg_addr == 0) fmt <= reg_wdata[0];
      if (hit && !pm) flag <= 1;
      else if (reg_write && reg_addr == 1 && reg_wdata[0]) flag <= 0;
   end
end
task chk(input [15:0] g, input [15:0] e);
   num_checks++;
   if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
   end
endtask
always @(negedge clk) if (nrst) begin
   chk(reg_rdata, rd);
   chk(reg_rdata, rd);
   chk({8'h0, calendar_day_of_month_reg}, m[2]);
   chk({8'h0, calendar_month_reg}, m[3]);
   chk(calendar_year_reg, m[4]);
   chk({15'h0, bcd_mode}, {15'h0, fmt});
   chk({15'h0, alarm_event}, {15'h0, ev});
   chk({15'h0, alarm_flag}, {15'h0, flag});
end
task print_verdict;
   $display("checks %0d errors %0d", num_checks, n_errors);
   if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
   else $display("TESTS FAILED");
   $finish;
endtask
//////////////////////////////////////////////////
// Small alarm values and time inputs so matches happen often
initial begin
   repeat (3) @(posedge clk);
   nrst <= 1;
   for (k = 0; k < 4000; k++) begin
      @(posedge clk);
      r = lfsr(r);
      reg_write <= r[15:14] == 1 && nrst;
      reg_read <= r[15:14] == 2 && nrst;
      reg_addr <= {r[3] & r[4], r[2:0]};
      reg_wdata <= {r[10:0], r[15:11]} & (r[2:0] > 4 ? 16'h8383 : 16'hffff);
      current_minute <= {6'h0, r[9:8]};
      current_hour <= {6'h0, r[7:6]};
      if (k == 2000) nrst <= 0;
      if (k == 2003) nrst <= 1;
   end
   print_verdict;
end
initial begin
   #100000;
   n_errors++;
   print_verdict;
end
endmodule // rtc_calendar_alarm_regs_tb_top
`default_nettype wire
